// File: core/mdio_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module mdio_debounce
   import mdio_pkg::*;
#(
   parameter int N = 8,
   parameter int CNT = DEB_CYC
) (
   // Clock group
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Raw and filtered levels
   input wire logic [N-1:0] din,
   output logic [N-1:0] dout
);
   localparam int CW = $clog2(CNT + 1);

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         logic meta_q; // First stage, read only by sync_q
         logic sync_q; // Second stage
         logic stab_q; // Accepted level
         logic [CW-1:0] cnt_q; // Stable-time counter
         // A level is taken only after it held for the full count
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
               stab_q <= 1'b0;
               cnt_q <= '0;
            end else if (ce) begin
               meta_q <= din[i];
               sync_q <= meta_q;
               if (sync_q == stab_q) begin
                  cnt_q <= '0;
               end else if (cnt_q == CW'(CNT - 1)) begin
                  stab_q <= sync_q;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         end
         assign dout[i] = stab_q;
      end
   endgenerate
endmodule
`default_nettype wire

// File: core/mdio_pkg.sv
`default_nettype none
package mdio_pkg;
   // Clock rate
   localparam int CLK_PERIOD_NS = 10;
   // Input filter time, rounded up to whole cycles
   localparam int DEB_TIME_NS = 20000;
   localparam int DEB_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Least hold time of the fault-clear input
   localparam int CLR_TIME_MS = 10;
   localparam int CLR_CYC = (CLR_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Width of one speed feedback pulse
   localparam int PULSE_TIME_US = 200;
   localparam int PULSE_CYC = (PULSE_TIME_US * 1000) / CLK_PERIOD_NS;
   // Half period of the fault indicator blink
   localparam int BLINK_TIME_MS = 250;
   localparam int BLINK_CYC = (BLINK_TIME_MS * 1000000) / CLK_PERIOD_NS;
   // Cycles between two ramp steps
   localparam int RAMP_DIV = 100;
   localparam int RAMP_W = 7;
   // Widths
   localparam int SPD_W = 16;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int N_SPEEDS = 8;
   localparam int ALM_W = 4;
   localparam int CTRL_W = 4;
   // Register offsets
   localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] REG_ACCEL = 5'h01;
   localparam logic [ADDR_W-1:0] REG_DECEL = 5'h02;
   localparam logic [ADDR_W-1:0] REG_INT_SPEED = 5'h03;
   localparam logic [ADDR_W-1:0] REG_UV_LEVEL = 5'h04;
   localparam logic [ADDR_W-1:0] REG_OL_LEVEL = 5'h05;
   localparam logic [ADDR_W-1:0] REG_STATUS = 5'h06;
   localparam logic [ADDR_W-1:0] REG_TABLE = 5'h08;
   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam logic [SPD_W-1:0] ACCEL_RST = 16'h0010;
   localparam logic [SPD_W-1:0] DECEL_RST = 16'h0010;
   localparam logic [SPD_W-1:0] INT_SPEED_RST = 16'h0400;
   localparam logic [SPD_W-1:0] UV_LEVEL_RST = 16'h0e66;
   localparam logic [SPD_W-1:0] OL_LEVEL_RST = 16'hf000;
   // Alarm bits; the low three survive the fault-clear input
   localparam int ALM_OVERCUR = 0;
   localparam int ALM_NVM = 1;
   localparam int ALM_COMSW = 2;
   localparam int ALM_GENERAL = 3;
   localparam logic [ALM_W-1:0] ALM_HARD_MASK = 4'h7;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_STOP = 2'b00,
      ST_RUN = 2'b01,
      ST_DECEL = 2'b10,
      ST_FAULT = 2'b11
   } mdio_state_t;
   // Opto input group, conducting = 1
   typedef struct packed {
      logic brake_rel;
      logic clr;
      logic bit2;
      logic bit1;
      logic src;
      logic stop_style;
      logic ccw;
      logic cw;
   } mdio_in_t;
   // Control register fields
   typedef struct packed {
      logic test_mode;
      logic multi_en;
      logic brake_delay;
      logic dir_inv;
   } mdio_ctrl_t;
endpackage
`default_nettype wire

// File: core/mdio_speed_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mdio_speed_mem
   import mdio_pkg::*;
#(
   parameter int W = SPD_W,
   parameter int D = N_SPEEDS
) (
   // Clock group
   input wire logic clk,
   input wire logic ce,
   // Write side
   input wire logic we,
   input wire logic [$clog2(D)-1:0] waddr,
   input wire logic [W-1:0] wdata,
   // Read side, one cycle latency
   input wire logic [$clog2(D)-1:0] raddr,
   output logic [W-1:0] rdata
);
   logic [W-1:0] mem [D]; // Speed settings, no reset: software loads them
   logic [W-1:0] rdata_q; // Registered read word

   // Write and registered read
   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata_q <= mem[raddr];
      end
   end
   assign rdata = rdata_q;
endmodule
`default_nettype wire

// File: core/mdio_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Clockwise command runs clockwise with ramp
// - Counterclockwise command runs counterclockwise with ramp
// - Both commands together stop at once
// - Release decelerates or stops per stop style
// - Source select picks external or internal speed
// - Three select bits pick eight table speeds
// - Control bit inverts physical rotation direction
// - Clear input ignored while any command active
// - Three hard alarms clear only by reset
// - Stopped brake follows brake release input
// - Brake release input ignored during alarm
// - Feedback pulse per tick, 0.2 ms wide
// - Alarm opens fault output, blinks indicator
// - Alarm removes drive; brake variant engages brake
// - Option delays brake until motor stopped
// - Warning output follows causes, motor keeps running
// - Overheat, undervoltage, overload warnings, levels programmable
// - Command held across reconfiguration prohibits running
// - Every pin level means opto conducting
module mdio_top
   import mdio_pkg::*;
#(
   parameter bit BRAKE_VARIANT = 1'b1,
   parameter int DEB_CNT = DEB_CYC,
   parameter int CLR_CNT = CLR_CYC,
   parameter int PULSE_CNT = PULSE_CYC,
   parameter int BLINK_CNT = BLINK_CYC
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Opto-isolated control inputs
   input wire logic run_cw_cmd,
   input wire logic run_ccw_cmd,
   input wire logic stop_style_sel,
   input wire logic speed_src_sel,
   input wire logic speed_sel_bit1,
   input wire logic speed_sel_bit2,
   input wire logic fault_clear_in,
   input wire logic brake_release_in,
   // Drive-side measurements and events
   input wire logic [SPD_W-1:0] ext_speed_in,
   input wire logic [SPD_W-1:0] supply_level_in,
   input wire logic [SPD_W-1:0] load_torque_in,
   input wire logic overheat_in,
   input wire logic [ALM_W-1:0] fault_cause_in,
   input wire logic motor_stopped_in,
   input wire logic motor_tick_in,
   // Opto outputs and indicator
   output logic fault_out_nc,
   output logic fault_indicator,
   output logic warn_out,
   output logic speed_pulse_out,
   // Power stage commands
   output logic motor_dir_out,
   output logic drive_en_out,
   output logic brake_release_out,
   output logic [SPD_W-1:0] speed_cmd_out
);
   localparam int CLR_W = $clog2(CLR_CNT + 1);
   localparam int PUL_W = $clog2(PULSE_CNT + 1);
   localparam int BLK_W = $clog2(BLINK_CNT + 1);

   // Input filtering
   mdio_in_t raw_in; // Pins gathered
   mdio_in_t in_db; // Filtered levels
   assign raw_in = {brake_release_in, fault_clear_in, speed_sel_bit2, speed_sel_bit1,
                    speed_src_sel, stop_style_sel, run_ccw_cmd, run_cw_cmd};

   // Every pin is read as opto on = 1, then filtered
   mdio_debounce #(
      .N($bits(mdio_in_t)),
      .CNT(DEB_CNT)
   ) u_deb (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .din(raw_in),
      .dout(in_db)
   );

   // Software registers
   mdio_ctrl_t ctrl_q; // Mode bits
   logic [SPD_W-1:0] accel_q; // Ramp-up step per tick
   logic [SPD_W-1:0] decel_q; // Ramp-down step per tick
   logic [SPD_W-1:0] int_speed_q; // Internal speed setting
   logic [SPD_W-1:0] uv_level_q; // Undervoltage warning level
   logic [SPD_W-1:0] ol_level_q; // Overload warning level
   logic [DATA_W-1:0] rdata_q; // Read word, valid one cycle after strobe

   // Sequencer and drive state
   mdio_state_t st_q, st_d;
   logic [SPD_W-1:0] speed_q, speed_d; // Commanded speed
   logic dir_q, dir_d; // Requested direction, 1 = clockwise
   logic [SPD_W-1:0] target_q; // Selected speed reference
   logic [RAMP_W-1:0] ramp_cnt_q; // Ramp tick divider

   // Alarm, clear, warning state
   logic [ALM_W-1:0] alarm_q, alarm_d; // Latched alarms
   logic [CLR_W-1:0] clr_cnt_q; // Clear hold time
   logic clr_prev_q; // Clear level one cycle ago
   logic prohib_q; // Operation prohibited
   logic [2:0] warn_q; // Overload, undervoltage, overheat

   // Outputs and timers
   logic [PUL_W-1:0] pul_cnt_q; // Pulse time left
   logic pulse_q;
   logic [BLK_W-1:0] blk_cnt_q; // Blink timer
   logic blink_q;
   logic fault_nc_q, ind_q, warn_out_q, dir_out_q, drv_en_q, brake_q;

   // Bus decode
   wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
   wire wr_accel = reg_wr && (reg_addr == REG_ACCEL);
   wire wr_decel = reg_wr && (reg_addr == REG_DECEL);
   wire wr_int = reg_wr && (reg_addr == REG_INT_SPEED);
   wire wr_uv = reg_wr && (reg_addr == REG_UV_LEVEL);
   wire wr_ol = reg_wr && (reg_addr == REG_OL_LEVEL);
   wire wr_tab = reg_wr && (reg_addr[ADDR_W-1:3] == REG_TABLE[ADDR_W-1:3]);
   mdio_ctrl_t ctrl_new;
   assign ctrl_new = reg_wdata[CTRL_W-1:0];
   // Leaving test mode or changing the terminal map counts as reconfiguration
   wire cfg_event = wr_ctrl && ((ctrl_q.test_mode && !ctrl_new.test_mode) ||
                                (ctrl_q.multi_en != ctrl_new.multi_en));

   // Command decode
   wire run_any = in_db.cw | in_db.ccw;
   wire both_cmd = in_db.cw & in_db.ccw;
   wire one_cmd = in_db.cw ^ in_db.ccw;
   wire alarm_any = |alarm_q;
   wire ramp_tick = (ramp_cnt_q == RAMP_W'(RAMP_DIV - 1));

   // Speed source: table index or two-speed switch
   logic [SPD_W-1:0] tab_rdata;
   wire [2:0] tab_idx = {in_db.bit2, in_db.bit1, in_db.src};
   wire [SPD_W-1:0] two_speed = in_db.src ? ext_speed_in : int_speed_q;
   wire [SPD_W-1:0] target_d = ctrl_q.multi_en ? tab_rdata : two_speed;

   mdio_speed_mem #(
      .W(SPD_W),
      .D(N_SPEEDS)
   ) u_tab (
      .clk(clk),
      .ce(ce),
      .we(wr_tab),
      .waddr(reg_addr[2:0]),
      .wdata(reg_wdata[SPD_W-1:0]),
      .raddr(tab_idx),
      .rdata(tab_rdata)
   );

   // Saturating step toward a goal
   function automatic logic [SPD_W-1:0] step_to(input logic [SPD_W-1:0] cur, input logic [SPD_W-1:0] tgt,
                                                 input logic [SPD_W-1:0] up, input logic [SPD_W-1:0] dn);
      logic [SPD_W-1:0] diff;
      diff = (cur < tgt) ? tgt - cur : cur - tgt;
      if (cur < tgt) begin
         step_to = (diff > up) ? cur + up : tgt;
      end else begin
         step_to = (diff > dn) ? cur - dn : tgt;
      end
   endfunction

   // Ramp steps only on divider ticks
   wire [SPD_W-1:0] spd_ramp = ramp_tick ? step_to(speed_q, target_q, accel_q, decel_q) : speed_q;
   wire [SPD_W-1:0] spd_stop = ramp_tick ? step_to(speed_q, '0, accel_q, decel_q) : speed_q;

   // Run/stop sequencer
   always_comb begin
      st_d = st_q;
      speed_d = speed_q;
      dir_d = dir_q;
      if (alarm_any) begin
         // Drive removed, motor coasts
         st_d = ST_FAULT;
         speed_d = '0;
      end else if (both_cmd) begin
         st_d = ST_STOP;
         speed_d = '0;
      end else if (one_cmd && !prohib_q) begin
         if (speed_q != '0 && dir_q != in_db.cw) begin
            // Reversal: slow to zero before turning round
            st_d = ST_DECEL;
            speed_d = spd_stop;
         end else begin
            st_d = ST_RUN;
            dir_d = in_db.cw;
            speed_d = spd_ramp;
         end
      end else begin
         unique case (st_q)
            ST_RUN: begin
               if (in_db.stop_style) begin
                  st_d = ST_DECEL;
                  speed_d = spd_stop;
               end else begin
                  st_d = ST_STOP;
                  speed_d = '0;
               end
            end
            ST_DECEL: begin
               speed_d = spd_stop;
               if (speed_q == '0) begin
                  st_d = ST_STOP;
               end
            end
            ST_STOP: begin
               speed_d = '0;
            end
            ST_FAULT: begin
               // Alarm gone: wait for a fresh command
               st_d = ST_STOP;
            end
         endcase
      end
   end

   // Clear accepted on release after a long enough hold, never while running
   wire clr_held = (clr_cnt_q >= CLR_W'(CLR_CNT));
   wire clr_ok = clr_prev_q && !in_db.clr && clr_held && !run_any;
   // Hard alarms are outside the clear mask; a new cause wins over the clear
   assign alarm_d = (alarm_q & ~(clr_ok ? ~ALM_HARD_MASK : '0)) | fault_cause_in;

   // Warning causes, levels from software
   wire [2:0] warn_d = {load_torque_in > ol_level_q, supply_level_in < uv_level_q, overheat_in};

   // Brake: held unless running, released on request only without alarm
   wire brake_d = !BRAKE_VARIANT ? 1'b0 :
                  (|alarm_d) ? (ctrl_q.brake_delay & ~motor_stopped_in) :
                  (st_d == ST_RUN || st_d == ST_DECEL) ? 1'b1 : in_db.brake_rel;

   // Register writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RST;
         accel_q <= ACCEL_RST;
         decel_q <= DECEL_RST;
         int_speed_q <= INT_SPEED_RST;
         uv_level_q <= UV_LEVEL_RST;
         ol_level_q <= OL_LEVEL_RST;
      end else if (ce) begin
         if (wr_ctrl) ctrl_q <= ctrl_new;
         if (wr_accel) accel_q <= reg_wdata[SPD_W-1:0];
         if (wr_decel) decel_q <= reg_wdata[SPD_W-1:0];
         if (wr_int) int_speed_q <= reg_wdata[SPD_W-1:0];
         if (wr_uv) uv_level_q <= reg_wdata[SPD_W-1:0];
         if (wr_ol) ol_level_q <= reg_wdata[SPD_W-1:0];
      end
   end

   // Read mux; the speed table is write-only and reads as zero
   wire [DATA_W-1:0] rd_mux =
      (reg_addr == REG_CTRL) ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_q} :
      (reg_addr == REG_ACCEL) ? {16'h0000, accel_q} :
      (reg_addr == REG_DECEL) ? {16'h0000, decel_q} :
      (reg_addr == REG_INT_SPEED) ? {16'h0000, int_speed_q} :
      (reg_addr == REG_UV_LEVEL) ? {16'h0000, uv_level_q} :
      (reg_addr == REG_OL_LEVEL) ? {16'h0000, ol_level_q} :
      (reg_addr == REG_STATUS) ? {speed_q, 6'h00, st_q, warn_q, prohib_q, alarm_q} :
      32'h0000_0000;

   // Read data register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= '0;
      end else if (ce) begin
         rdata_q <= reg_rd ? rd_mux : '0;
      end
   end

   // Sequencer, ramp divider and reference
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= ST_STOP;
         speed_q <= '0;
         dir_q <= 1'b1;
         target_q <= '0;
         ramp_cnt_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
         speed_q <= speed_d;
         dir_q <= dir_d;
         target_q <= target_d;
         ramp_cnt_q <= ramp_tick ? '0 : ramp_cnt_q + 1'b1;
      end
   end

   // Alarm latch, clear timing, prohibit flag, warnings
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alarm_q <= '0;
         clr_cnt_q <= '0;
         clr_prev_q <= 1'b0;
         prohib_q <= 1'b0;
         warn_q <= '0;
      end else if (ce) begin
         alarm_q <= alarm_d;
         clr_prev_q <= in_db.clr;
         // Hold time restarts if a command shows up mid-press
         if (!in_db.clr || run_any) clr_cnt_q <= '0;
         else if (!clr_held) clr_cnt_q <= clr_cnt_q + 1'b1;
         // Release of the command wins over the set
         prohib_q <= run_any && (prohib_q || cfg_event);
         warn_q <= warn_d;
      end
   end

   // Feedback pulse stretcher; a tick during a pulse restarts it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pul_cnt_q <= '0;
         pulse_q <= 1'b0;
      end else if (ce) begin
         if (motor_tick_in) begin
            pul_cnt_q <= PUL_W'(PULSE_CNT - 1);
            pulse_q <= 1'b1;
         end else if (pul_cnt_q != '0) begin
            pul_cnt_q <= pul_cnt_q - 1'b1;
         end else begin
            pulse_q <= 1'b0;
         end
      end
   end

   // Blink timer runs only while an alarm is latched
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         blk_cnt_q <= '0;
         blink_q <= 1'b1;
      end else if (ce) begin
         if (!alarm_any || blk_cnt_q == BLK_W'(BLINK_CNT - 1)) begin
            blk_cnt_q <= '0;
            blink_q <= alarm_any ? ~blink_q : 1'b1;
         end else begin
            blk_cnt_q <= blk_cnt_q + 1'b1;
         end
      end
   end

   // Output registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_nc_q <= 1'b0;
         ind_q <= 1'b0;
         warn_out_q <= 1'b0;
         dir_out_q <= 1'b0;
         drv_en_q <= 1'b0;
         brake_q <= 1'b0;
      end else if (ce) begin
         fault_nc_q <= ~(|alarm_d);
         ind_q <= (|alarm_d) & blink_q;
         warn_out_q <= (|warn_d) | prohib_q;
         dir_out_q <= dir_d ^ ctrl_q.dir_inv;
         drv_en_q <= (st_d == ST_RUN) || (st_d == ST_DECEL);
         brake_q <= brake_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign fault_out_nc = fault_nc_q;
   assign fault_indicator = ind_q;
   assign warn_out = warn_out_q;
   assign speed_pulse_out = pulse_q;
   assign motor_dir_out = dir_out_q;
   assign drive_en_out = drv_en_q;
   assign brake_release_out = brake_q;
   assign speed_cmd_out = speed_q;

   // Pulse length seen from outside
   logic [PUL_W:0] hi_len_q;
   always_ff @(posedge clk) begin
      if (sys_rst) hi_len_q <= '0;
      else if (ce) hi_len_q <= pulse_q ? hi_len_q + 1'b1 : '0;
   end

   AST_CW_DIR: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !alarm_any && !prohib_q && in_db.cw && !in_db.ccw && speed_q == '0
      |=> motor_dir_out == ~$past(ctrl_q.dir_inv) && st_q == ST_RUN)
      else $error("clockwise run not started");
   AST_CCW_DIR: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !alarm_any && !prohib_q && in_db.ccw && !in_db.cw && speed_q == '0
      |=> motor_dir_out == $past(ctrl_q.dir_inv) && st_q == ST_RUN)
      else $error("counterclockwise run not started");
   AST_BOTH_STOP: assert property (@(posedge clk) disable iff (sys_rst)
      ce && both_cmd |=> speed_cmd_out == '0 && !(st_q == ST_RUN))
      else $error("both commands did not stop the motor");
   AST_RELEASE_STYLE: assert property (@(posedge clk) disable iff (sys_rst)
      ce && st_q == ST_RUN && !run_any && !alarm_any
      |=> (st_q == ST_DECEL) == $past(in_db.stop_style) && ($past(in_db.stop_style) || speed_cmd_out == '0))
      else $error("wrong stop style on release");
   AST_SOURCE: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !sys_rst && !ctrl_q.multi_en |=> target_q == ($past(in_db.src) ? $past(ext_speed_in) : $past(int_speed_q)))
      else $error("speed source select not honoured");
   AST_CLR_IGNORED: assert property (@(posedge clk) disable iff (sys_rst)
      ce && run_any |=> (alarm_q & $past(alarm_q)) == $past(alarm_q))
      else $error("alarm cleared while a command was active");
   AST_HARD_ALARM: assert property (@(posedge clk) disable iff (sys_rst)
      alarm_q[ALM_OVERCUR] |=> alarm_q[ALM_OVERCUR] && ($past(alarm_q[ALM_NVM]) -> alarm_q[ALM_NVM]))
      else $error("hard alarm cleared without reset");
   AST_BRAKE_ALARM: assert property (@(posedge clk) disable iff (sys_rst)
      ce && BRAKE_VARIANT && (|alarm_d) && !ctrl_q.brake_delay |=> !brake_release_out)
      else $error("brake released during alarm");
   AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(speed_pulse_out) |-> hi_len_q >= (PUL_W+1)'(PULSE_CNT))
      else $error("feedback pulse too short");
   AST_FAULT_OUT: assert property (@(posedge clk) disable iff (sys_rst)
      ce && alarm_any && !clr_ok |=> !fault_out_nc && !drive_en_out)
      else $error("fault output still conducting during alarm");
   AST_WARN: assert property (@(posedge clk) disable iff (sys_rst)
      ce && overheat_in |=> warn_out)
      else $error("warning output not raised");
   AST_PROHIB: assert property (@(posedge clk) disable iff (sys_rst)
      prohib_q && run_any |-> !(st_d == ST_RUN))
      else $error("ran while operation prohibited");

   COV_RUN_DECEL: cover property (@(posedge clk) disable iff (sys_rst)
      st_q == ST_RUN ##1 st_q == ST_DECEL ##[1:1000] st_q == ST_STOP);
   COV_ALARM_CLEAR: cover property (@(posedge clk) disable iff (sys_rst)
      alarm_q[ALM_GENERAL] ##1 clr_ok ##1 !alarm_any);
   COV_PROHIB: cover property (@(posedge clk) disable iff (sys_rst) $rose(prohib_q));
endmodule
`default_nettype wire

// File: testbench/mdio_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side: clear sequencing and shaft ticks
module mdio_ctrl_model (
   // Clock
   input wire logic clk,
   // Bench requests and drive speed
   input wire logic clr_req,
   input wire logic [15:0] speed,
   // Pin levels, 1 = opto conducting
   output logic clr_pin,
   output logic tick,
   output logic stopped
);
   logic [6:0] hold_q = 7'h0; // Clear hold count
   logic [4:0] tk_q = 5'h0; // Tick spacing
   // Hold twice the scaled minimum so filter delay never shortens it
   always_ff @(posedge clk) begin
      hold_q <= clr_req ? 7'h28 : (hold_q != 7'h0 ? hold_q - 7'h1 : hold_q);
      tk_q <= tk_q + 5'h1;
   end
   assign clr_pin = hold_q != 7'h0;
   // Shaft turns only while speed is commanded
   assign tick = (speed != 16'h0) && (tk_q == 5'h0);
   assign stopped = speed == 16'h0;
endmodule
`default_nettype wire

// File: testbench/mdio_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mdio_top_tb;
   import mdio_pkg::*;
   // Bench-side pins
   logic clk = 1'h0, sys_rst = 1'h1, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, rd_q = 1'h0, clr_req = 1'h0;
   logic run_cw_cmd = 1'h0, run_ccw_cmd = 1'h0, stop_style_sel = 1'h0, speed_src_sel = 1'h0;
   logic speed_sel_bit1 = 1'h0, speed_sel_bit2 = 1'h0, brake_release_in = 1'h0, overheat_in = 1'h0;
   logic [ADDR_W-1:0] reg_addr = 5'h0;
   logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
   logic [SPD_W-1:0] ext_speed_in = 16'h0, supply_level_in = 16'hffff, load_torque_in = 16'h0, speed_cmd_out, d;
   logic [ALM_W-1:0] fault_cause_in = 4'h0;
   logic fault_clear_in, motor_stopped_in, motor_tick_in, fault_out_nc, fault_indicator, warn_out;
   logic speed_pulse_out, motor_dir_out, drive_en_out, brake_release_out;
   logic [63:0] notes[$], n; // Expected word and mask per read
   logic [1:0] seen = 2'h0; // Indicator levels met during an alarm
   int fail_count = 0, checks_done = 0;
   // Short counts keep the run brief
   mdio_top #(.DEB_CNT(4), .CLR_CNT(20), .PULSE_CNT(5), .BLINK_CNT(8)) mdio_top_i (.clk, .sys_rst, .ce,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .run_cw_cmd, .run_ccw_cmd, .stop_style_sel,
      .speed_src_sel, .speed_sel_bit1, .speed_sel_bit2, .fault_clear_in, .brake_release_in, .ext_speed_in,
      .supply_level_in, .load_torque_in, .overheat_in, .fault_cause_in, .motor_stopped_in, .motor_tick_in,
      .fault_out_nc, .fault_indicator, .warn_out, .speed_pulse_out, .motor_dir_out, .drive_en_out,
      .brake_release_out, .speed_cmd_out);
   mdio_ctrl_model mdio_ctrl_model_i (.clk, .clr_req, .speed(speed_cmd_out), .clr_pin(fault_clear_in),
      .tick(motor_tick_in), .stopped(motor_stopped_in));
   // Free-running clock
   always #5 clk = ~clk;
   task automatic w(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %h %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   // Read answer is judged by the watcher
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      notes.push_back({e, m});
      @(posedge clk);
      reg_rd <= 1'h0;
   endtask
   // Levels then filter settle time
   task automatic cmd(input logic cw, input logic ccw, input logic ss);
      @(posedge clk);
      run_cw_cmd <= cw;
      run_ccw_cmd <= ccw;
      stop_style_sel <= ss;
      w(10);
   endtask
   task automatic clr();
      @(posedge clk);
      clr_req <= 1'h1;
      @(posedge clk);
      clr_req <= 1'h0;
      w(60);
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watcher: read data stand one cycle after the strobe
   always @(posedge clk) begin
      rd_q <= reg_rd;
      if (rd_q) begin
         n = notes.pop_front();
         chk(reg_rdata & n[31:0], n[63:32]);
      end
   end
   // Main sequence
   initial begin
      d = 16'($urandom(32'hc0d6c645));
      ext_speed_in = 16'($urandom);
      w(20);
      sys_rst <= 1'h0;
      rd(REG_ACCEL, 32'(ACCEL_RST), 32'hffff);
      rd(REG_OL_LEVEL, 32'(OL_LEVEL_RST), 32'hffff);
      rd(5'h07, 32'h0, 32'hffffffff);
      d = {4'h1, 12'($urandom)};
      wr(REG_INT_SPEED, {16'h0, d});
      rd(REG_INT_SPEED, {16'h0, d}, 32'hffff);
      cmd(1'h1, 1'h0, 1'h0);
      rd(REG_STATUS, 32'h100, 32'h300);
      chk({31'h0, motor_dir_out}, 32'h1);
      chk({31'h0, drive_en_out}, 32'h1);
      w(500);
      cmd(1'h0, 1'h0, 1'h1);
      rd(REG_STATUS, 32'h200, 32'h300);
      w(800);
      rd(REG_STATUS, 32'h0, 32'h300);
      wr(REG_CTRL, 32'h1);
      cmd(1'h0, 1'h1, 1'h0);
      rd(REG_STATUS, 32'h100, 32'h300);
      chk({31'h0, motor_dir_out}, 32'h1);
      cmd(1'h1, 1'h1, 1'h0);
      rd(REG_STATUS, 32'h0, 32'hffff0300);
      cmd(1'h0, 1'h0, 1'h0);
      brake_release_in <= 1'h1;
      overheat_in <= 1'h1;
      w(10);
      chk({31'h0, brake_release_out}, 32'h1);
      rd(REG_STATUS, 32'h20, 32'h20);
      chk({31'h0, warn_out}, 32'h1);
      overheat_in <= 1'h0;
      supply_level_in <= 16'h0e65;
      w(3);
      rd(REG_STATUS, 32'h40, 32'h60);
      supply_level_in <= 16'hffff;
      fault_cause_in <= 4'h8;
      w(3);
      rd(REG_STATUS, 32'h308, 32'h30f);
      chk({31'h0, fault_out_nc}, 32'h0);
      // Indicator must show both levels while the alarm stands
      repeat (20) begin
         @(posedge clk);
         seen = seen | (2'h1 << fault_indicator);
      end
      chk({30'h0, seen}, 32'h3);
      fault_cause_in <= 4'h0;
      cmd(1'h1, 1'h0, 1'h0);
      clr();
      rd(REG_STATUS, 32'h8, 32'hf);
      cmd(1'h0, 1'h0, 1'h0);
      clr();
      rd(REG_STATUS, 32'h0, 32'hf);
      chk({31'h0, fault_out_nc}, 32'h1);
      fault_cause_in <= 4'h1;
      w(3);
      fault_cause_in <= 4'h0;
      clr();
      rd(REG_STATUS, 32'h1, 32'hf);
      chk({31'h0, brake_release_out}, 32'h0);
      // Mid-run reset is the only way out of a hard alarm
      sys_rst <= 1'h1;
      w(3);
      sys_rst <= 1'h0;
      wr(REG_ACCEL, 32'hffff);
      wr(REG_TABLE, {16'h0, d});
      cmd(1'h1, 1'h0, 1'h0);
      // Map change under a held command prohibits running
      wr(REG_CTRL, 32'h4);
      rd(REG_STATUS, 32'h10, 32'h310);
      chk({31'h0, warn_out}, 32'h1);
      cmd(1'h0, 1'h0, 1'h0);
      cmd(1'h1, 1'h0, 1'h0);
      w(110);
      rd(REG_STATUS, {d, 16'h0100}, 32'hffff0310);
      w(3);
      report_and_stop();
   end
   // Watchdog well past the roughly 1800 cycles needed
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
